// ==== uepc_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "uepc_regs.vh"
module uepc_ctrl #(
  parameter AW = 14,
  parameter integer PULSE_CYC = `UEPC_PULSE_CYC,
  parameter integer MAX_PULSES = `UEPC_MAX_PULSES
) (
  input wire sys_clk,
  input wire reset_n,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [1:0] cmd_op,
  input wire [AW-1:0] cmd_addr,
  input wire [7:0] cmd_data,
  output reg rsp_valid_r,
  output reg [7:0] rsp_data_r,
  output reg rsp_fail_r,
  output reg [4:0] rsp_pulses_r,
  output reg [AW-1:0] mem_addr_r,
  output reg chip_sel_n_r,
  output reg out_gate_n_r,
  output reg prog_strobe_n_r,
  output reg prog_supply_high_r,
  output reg identifier_voltage_line_r,
  input wire [7:0] data_lines_in,
  output reg [7:0] data_lines_out_r,
  output reg data_lines_oe_r
);
  // ----------------------------------------------------------------
  // States and helpers.
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_RSETUP = 4'h1;
  localparam [3:0] S_RSAMPLE = 4'h2;
  localparam [3:0] S_PSETUP = 4'h3;
  localparam [3:0] S_PULSE = 4'h4;
  localparam [3:0] S_PHOLD = 4'h5;
  localparam [3:0] S_VSETUP = 4'h6;
  localparam [3:0] S_VSAMPLE = 4'h7;
  localparam [3:0] S_OSETUP = 4'h8;
  localparam [3:0] S_OPULSE = 4'h9;
  localparam [3:0] S_OHOLD = 4'ha;
  localparam [3:0] S_DONE = 4'hb;
  localparam integer TW = 24;
  // The three-flop delay on the data pins is covered by the sample wait.
  localparam integer SAMPLE_CYC = `UEPC_ACCESS_CYC + 4;

  function [TW-1:0] to_tw;
    input integer v;
    begin
      to_tw = v[TW-1:0];
    end
  endfunction

  reg [3:0] state_r;
  reg [1:0] op_r;
  reg [7:0] wdata_r;
  reg [4:0] npulse_r;
  reg tload;
  reg [TW-1:0] tcount;
  wire tdone;
  reg [7:0] din_s1_r;
  reg [7:0] din_s2_r;
  reg [7:0] din_s3_r;

  uepc_timer #(.W(TW)) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  assign cmd_ready = (state_r == S_IDLE);

  // ----------------------------------------------------------------
  // Data pin synchroniser; only the settled pair is used.
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
      din_s3_r <= 8'h00;
    end else begin
      din_s1_r <= data_lines_in;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
    end
  end
  wire din_stable = (din_s2_r == din_s3_r);

  // ----------------------------------------------------------------
  // Timer loads on entry to each timed state (every state but S_IDLE and S_DONE).
  // ----------------------------------------------------------------
  always @* begin
    tload = 1'b0;
    tcount = {TW{1'b0}};
    case (state_r)
      S_IDLE: begin
        if (cmd_valid) begin
          tload = 1'b1;
          tcount = (cmd_op == `UEPC_OP_PROG) ? to_tw(`UEPC_SETUP_CYC)
                                              : to_tw(`UEPC_OESETUP_CYC);
        end
      end
      S_RSETUP, S_VSETUP: begin
        if (tdone) begin
          tload = 1'b1;
          tcount = to_tw(SAMPLE_CYC);
        end
      end
      S_PSETUP: begin
        if (tdone) begin
          tload = 1'b1;
          tcount = to_tw(PULSE_CYC);
        end
      end
      S_OSETUP: begin
        if (tdone) begin
          tload = 1'b1;
          tcount = to_tw(`UEPC_OVER_FACTOR * PULSE_CYC * npulse_r);
        end
      end
      S_PULSE, S_OPULSE: begin
        if (tdone) begin
          tload = 1'b1;
          tcount = to_tw(`UEPC_HOLD_CYC);
        end
      end
      S_PHOLD: begin
        if (tdone) begin
          tload = 1'b1;
          tcount = to_tw(`UEPC_OESETUP_CYC);
        end
      end
      S_RSAMPLE, S_VSAMPLE: begin
        // Pins still moving at the end of the window get one more window.
        if (tdone) begin
          tload = 1'b1;
          tcount = din_stable ? to_tw(`UEPC_SETUP_CYC) : to_tw(SAMPLE_CYC);
        end
      end
      default: begin
        tload = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer. Idle leaves the memory deselected in standby.
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      op_r <= `UEPC_OP_READ;
      wdata_r <= `UEPC_ERASED_BYTE;
      npulse_r <= 5'h00;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_fail_r <= 1'b0;
      rsp_pulses_r <= 5'h00;
      mem_addr_r <= {AW{1'b0}};
      chip_sel_n_r <= 1'b1;
      out_gate_n_r <= 1'b1;
      prog_strobe_n_r <= 1'b1;
      prog_supply_high_r <= 1'b0;
      identifier_voltage_line_r <= 1'b0;
      data_lines_out_r <= 8'h00;
      data_lines_oe_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          chip_sel_n_r <= 1'b1;
          out_gate_n_r <= 1'b1;
          prog_strobe_n_r <= 1'b1;
          prog_supply_high_r <= 1'b0;
          identifier_voltage_line_r <= 1'b0;
          data_lines_oe_r <= 1'b0;
          if (cmd_valid) begin
            op_r <= cmd_op;
            npulse_r <= 5'h00;
            rsp_fail_r <= 1'b0;
            chip_sel_n_r <= 1'b0;
            if (cmd_op == `UEPC_OP_PROG) begin
              mem_addr_r <= cmd_addr;
              wdata_r <= cmd_data;
              prog_supply_high_r <= 1'b1;
              data_lines_out_r <= cmd_data;
              data_lines_oe_r <= 1'b1;
              state_r <= S_PSETUP;
            end else if (cmd_op == `UEPC_OP_IDENT) begin
              // Other address lines stay low; only the lowest bit picks the code.
              mem_addr_r <= {{(AW-1){1'b0}}, cmd_addr[0]};
              identifier_voltage_line_r <= 1'b1;
              state_r <= S_RSETUP;
            end else begin
              mem_addr_r <= cmd_addr;
              state_r <= S_RSETUP;
            end
          end
        end
        S_RSETUP: begin
          if (tdone) begin
            out_gate_n_r <= 1'b0;
            state_r <= S_RSAMPLE;
          end
        end
        S_RSAMPLE: begin
          if (tdone && din_stable) begin
            rsp_data_r <= din_s3_r;
            out_gate_n_r <= 1'b1;
            state_r <= S_DONE;
          end
        end
        S_PSETUP: begin
          if (tdone) begin
            prog_strobe_n_r <= 1'b0;
            npulse_r <= npulse_r + 5'h01;
            state_r <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (tdone) begin
            prog_strobe_n_r <= 1'b1;
            state_r <= S_PHOLD;
          end
        end
        S_PHOLD: begin
          if (tdone) begin
            data_lines_oe_r <= 1'b0;
            state_r <= S_VSETUP;
          end
        end
        S_VSETUP: begin
          if (tdone) begin
            out_gate_n_r <= 1'b0;
            state_r <= S_VSAMPLE;
          end
        end
        S_VSAMPLE: begin
          if (tdone && din_stable) begin
            out_gate_n_r <= 1'b1;
            rsp_data_r <= din_s3_r;
            if (din_s3_r == wdata_r) begin
              data_lines_oe_r <= 1'b1;
              state_r <= S_OSETUP;
            end else if (npulse_r < MAX_PULSES) begin
              data_lines_oe_r <= 1'b1;
              state_r <= S_PSETUP;
            end else begin
              rsp_fail_r <= 1'b1;
              state_r <= S_DONE;
            end
          end
        end
        S_OSETUP: begin
          if (tdone) begin
            prog_strobe_n_r <= 1'b0;
            state_r <= S_OPULSE;
          end
        end
        S_OPULSE: begin
          if (tdone) begin
            prog_strobe_n_r <= 1'b1;
            state_r <= S_OHOLD;
          end
        end
        S_OHOLD: begin
          if (tdone) begin
            data_lines_oe_r <= 1'b0;
            state_r <= S_DONE;
          end
        end
        S_DONE: begin
          rsp_valid_r <= 1'b1;
          rsp_pulses_r <= npulse_r;
          chip_sel_n_r <= 1'b1;
          prog_supply_high_r <= 1'b0;
          identifier_voltage_line_r <= 1'b0;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== uepc_regs.vh ====
`ifndef UEPC_REGS_VH
`define UEPC_REGS_VH
// ----------------------------------------------------------------
// Timing figures and derived cycle counts at a 40 MHz clock.
// ----------------------------------------------------------------
`define UEPC_CLK_MHZ 40
`define UEPC_SETUP_NS 2000
`define UEPC_SETUP_CYC ((`UEPC_SETUP_NS * `UEPC_CLK_MHZ + 999) / 1000)
`define UEPC_HOLD_NS 2000
`define UEPC_HOLD_CYC ((`UEPC_HOLD_NS * `UEPC_CLK_MHZ + 999) / 1000)
`define UEPC_OESETUP_NS 2000
`define UEPC_OESETUP_CYC ((`UEPC_OESETUP_NS * `UEPC_CLK_MHZ + 999) / 1000)
`define UEPC_PULSE_US 1000
`define UEPC_PULSE_CYC (`UEPC_PULSE_US * `UEPC_CLK_MHZ)
`define UEPC_OVER_FACTOR 3
`define UEPC_ACCESS_NS 450
`define UEPC_ACCESS_CYC ((`UEPC_ACCESS_NS * `UEPC_CLK_MHZ + 999) / 1000)
`define UEPC_MAX_PULSES 25
`define UEPC_ERASED_BYTE 8'hff
// ----------------------------------------------------------------
// Operation codes on the command port.
// ----------------------------------------------------------------
`define UEPC_OP_READ 2'h0
`define UEPC_OP_PROG 2'h1
`define UEPC_OP_IDENT 2'h2
`endif

// ==== uepc_timer.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Down counter that pulses done when a loaded wait has elapsed.
// ----------------------------------------------------------------
module uepc_timer #(
  parameter W = 24
) (
  input wire sys_clk,
  input wire reset_n,
  input wire load,
  input wire [W-1:0] count,
  output wire done
);
  reg [W-1:0] cnt_r;
  reg run_r;
  assign done = run_r && (cnt_r == {{(W-1){1'b0}}, 1'b1});
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
        run_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== uepc_ctrl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin checks.
// ----
module uepc_ctrl_assertions #(
  parameter AW = 14,
  parameter integer PULSE_CYC = 40,
  parameter integer MAX_PULSES = 25
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic rsp_valid_r,
  input wire logic rsp_fail_r,
  input wire logic [4:0] rsp_pulses_r,
  input wire logic [AW-1:0] mem_addr_r,
  input wire logic chip_sel_n_r,
  input wire logic out_gate_n_r,
  input wire logic prog_strobe_n_r,
  input wire logic prog_supply_high_r,
  input wire logic identifier_voltage_line_r,
  input wire logic [7:0] data_lines_out_r,
  input wire logic data_lines_oe_r
);
  // A change shows one edge late, so 2 us of settling reads as one less.
  localparam int SETTLE = 79;
  localparam int HOLD = 80;
  int stab_r, high_r, low_r;
  always @(posedge sys_clk) begin
    if (!reset_n || !$stable({mem_addr_r, data_lines_out_r & {8{data_lines_oe_r}},
        chip_sel_n_r, prog_supply_high_r, identifier_voltage_line_r, prog_strobe_n_r,
        data_lines_oe_r}))
      stab_r <= 0;
    else if (stab_r < 1000)
      stab_r <= stab_r + 1;
    high_r <= !reset_n ? 1000 : !prog_strobe_n_r ? 0 : high_r < 1000 ? high_r + 1 : high_r;
    low_r <= prog_strobe_n_r ? 0 : low_r + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  setup_time_a: assert property ($fell(prog_strobe_n_r) |-> stab_r >= SETTLE)
    else $error("strobe fell too soon");
  pulse_width_a: assert property ($rose(prog_strobe_n_r) |-> low_r == PULSE_CYC ||
    (low_r % (3 * PULSE_CYC) == 0 && low_r <= 3 * PULSE_CYC * MAX_PULSES))
    else $error("bad pulse width");
  hold_time_a: assert property (!$stable({mem_addr_r, data_lines_out_r, data_lines_oe_r})
    |-> high_r >= HOLD) else $error("hold too short");
  verify_wait_a: assert property ($fell(out_gate_n_r) |-> stab_r >= SETTLE)
    else $error("gate fell too soon");
  strobe_mode_a: assert property (!prog_strobe_n_r |-> prog_supply_high_r &&
    !chip_sel_n_r && out_gate_n_r && data_lines_oe_r) else $error("bad program pins");
  no_contention_a: assert property (!out_gate_n_r |-> !data_lines_oe_r)
    else $error("drives while gated");
  ident_mode_a: assert property (identifier_voltage_line_r |-> !prog_supply_high_r &&
    mem_addr_r[AW-1:1] == 0) else $error("bad identifier pins");
  fail_count_a: assert property (rsp_valid_r && rsp_fail_r |-> rsp_pulses_r == MAX_PULSES)
    else $error("failed early");
  rsp_end_a: assert property (rsp_valid_r |-> prog_strobe_n_r && out_gate_n_r
    ##1 !rsp_valid_r) else $error("bad response end");
  cover property ($rose(prog_strobe_n_r) && low_r > PULSE_CYC);
  cover property (rsp_valid_r && rsp_fail_r);
  cover property ($fell(out_gate_n_r) && identifier_voltage_line_r);
endmodule
`default_nettype wire

// ==== uepc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Memory model.
// ----
module uepc_mem_model #(
  parameter int AW = 14,
  parameter int ACC = 12,
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value.
  parameter logic [7:0] PART = 8'ha5 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic sel_n,
  input wire logic gate_n,
  input wire logic strobe_n,
  input wire logic vpp,
  input wire logic vid,
  input wire logic [7:0] ctl_d,
  input wire logic ctl_oe,
  input wire logic [3:0] need,
  output logic [7:0] dq
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] last = 8'h00;
  logic strobe_d = 1'b1;
  logic vpp_d = 1'b0;
  int acc_cnt = 0;
  int pulses = 0;
  logic drv;
  logic [7:0] val;
  initial for (int i = 0; i < (1 << AW); i++) mem[i] = 8'hff;
  assign drv = !sel_n && !gate_n && strobe_n && acc_cnt >= ACC;
  assign val = vid ? (addr[0] ? PART : MAKER) : mem[addr];
  // A floated bus must not look like held data.
  assign dq = ctl_oe ? ctl_d : drv ? val : ~last;
  always @(posedge clk) begin
    strobe_d <= strobe_n;
    vpp_d <= vpp;
    acc_cnt <= (!sel_n && !gate_n && strobe_n) ? acc_cnt + 1 : 0;
    if (drv)
      last <= val;
    if (vpp && !vpp_d)
      pulses <= 0;
    else if (strobe_n && !strobe_d && !sel_n && vpp && gate_n) begin
      pulses <= pulses + 1;
      if (pulses + 1 >= need)
        mem[addr] <= mem[addr] & ctl_d;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench.
// ----
module tb_top;
  localparam int AW = 14;
  logic sys_clk = 0, reset_n = 0, cmd_valid = 0;
  logic [1:0] cmd_op = 0;
  logic [AW-1:0] cmd_addr = 0, mem_addr_r;
  logic [7:0] cmd_data = 0, rsp_data_r, data_lines_in, data_lines_out_r;
  logic [3:0] need = 1;
  logic [4:0] rsp_pulses_r;
  logic cmd_ready, rsp_valid_r, rsp_fail_r, chip_sel_n_r, out_gate_n_r, prog_strobe_n_r;
  logic prog_supply_high_r, identifier_voltage_line_r, data_lines_oe_r;
  logic [7:0] refm [int];
  int bad_count = 0, samples_checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  uepc_ctrl #(.AW(AW), .PULSE_CYC(40), .MAX_PULSES(25)) uepc_ctrl_i (.sys_clk(sys_clk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
    .rsp_fail_r(rsp_fail_r), .rsp_pulses_r(rsp_pulses_r), .mem_addr_r(mem_addr_r),
    .chip_sel_n_r(chip_sel_n_r), .out_gate_n_r(out_gate_n_r), .prog_strobe_n_r(prog_strobe_n_r),
    .prog_supply_high_r(prog_supply_high_r), .identifier_voltage_line_r(identifier_voltage_line_r),
    .data_lines_in(data_lines_in), .data_lines_out_r(data_lines_out_r),
    .data_lines_oe_r(data_lines_oe_r));
  uepc_mem_model #(.AW(AW)) uepc_mem_model_i (.clk(sys_clk), .addr(mem_addr_r),
    .sel_n(chip_sel_n_r), .gate_n(out_gate_n_r), .strobe_n(prog_strobe_n_r),
    .vpp(prog_supply_high_r), .vid(identifier_voltage_line_r), .ctl_d(data_lines_out_r),
    .ctl_oe(data_lines_oe_r), .need(need), .dq(data_lines_in));
  function automatic logic [7:0] rd(input logic [AW-1:0] a);
    return refm.exists(a) ? refm[a] : 8'hff;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge sys_clk); while (rsp_valid_r !== 1'b1);
  endtask
  task automatic prog(input logic [AW-1:0] a, input logic [7:0] d, input int k);
    logic [7:0] o;
    o = rd(a);
    need <= 4'(k);
    run(2'h1, a, d);
    refm[a] = o & d;
    chk("fail", 8'(rsp_fail_r), 8'((o & d) != d));
    chk("pulses", 8'(rsp_pulses_r), 8'(o == d ? 1 : (o & d) != d ? 25 : k));
    chk("verify", rsp_data_r, o & d);
    run(2'h0, a, 8'h00);
    chk("readback", rsp_data_r, o & d);
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(90000 * 25);
    bad_count++;
    close_out();
  end
  initial begin
    logic [AW-1:0] a;
    logic [7:0] d;
    int k;
    k = $urandom(32'hdbc3);
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = AW'($urandom);
      d = 8'($urandom);
      run(i[0] ? 2'h3 : 2'h0, a, 8'h00);
      chk("read", rsp_data_r, rd(a));
      prog(a, d, 1 + $urandom % 4);
      prog(a, i[0] ? ~d : d & 8'($urandom), 1 + $urandom % 4);
    end
    for (int i = 0; i < 2; i++) begin
      a = AW'($urandom);
      a[0] = i[0];
      run(2'h2, a, 8'h00);
      chk("ident", rsp_data_r, i ? 8'ha5 : 8'h5a);
    end
    close_out();
  end
endmodule
bind uepc_ctrl uepc_ctrl_assertions #(.AW(AW), .PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES))
  uepc_ctrl_assertions_i (.sys_clk(sys_clk), .reset_n(reset_n), .rsp_valid_r(rsp_valid_r),
  .rsp_fail_r(rsp_fail_r), .rsp_pulses_r(rsp_pulses_r), .mem_addr_r(mem_addr_r),
  .chip_sel_n_r(chip_sel_n_r), .out_gate_n_r(out_gate_n_r), .prog_strobe_n_r(prog_strobe_n_r),
  .prog_supply_high_r(prog_supply_high_r), .identifier_voltage_line_r(identifier_voltage_line_r),
  .data_lines_out_r(data_lines_out_r), .data_lines_oe_r(data_lines_oe_r));
`default_nettype wire
